// File: hw/hdcr_defs.svh
// Offsets, field positions, reset values and widths of the hub configuration register bank.
`ifndef HDCR_DEFS_SVH
`define HDCR_DEFS_SVH
`define HDCR_OFS_POLARITY   8'h0b
`define HDCR_OFS_UUID_FIRST 8'h10
`define HDCR_OFS_UUID_LAST  8'h1f
`define HDCR_OFS_LANG_LOW   8'h20
`define HDCR_OFS_LANG_HIGH  8'h21
`define HDCR_OFS_SER_LEN    8'h22
`define HDCR_BIT_UP_SWAP    0
`define HDCR_BIT_DOWN1_SWAP 1
`define HDCR_BIT_POL_GATE   7
`define HDCR_RST_LANG_LOW   8'h09
`define HDCR_RST_LANG_HIGH  8'h04
`define HDCR_RST_SER_LEN    6'h18
`define HDCR_SER_LEN_W      6
`define HDCR_SER_LEN_MAX    6'h20
`endif

// File: hw/hdcr_pkg.sv
// Types shared by the hub configuration register bank.
package hdcr_pkg;
  typedef logic [7:0] hdcr_byte_t;
  typedef logic [7:0] hdcr_addr_t;
endpackage

// File: hw/hdcr_regs.sv
// Hub descriptor configuration register bank with gated writes and descriptor outputs.
`timescale 1ns/100ps
`include "hdcr_defs.svh"
module hdcr_regs (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     wr_en_i,
  input  wire hdcr_pkg::hdcr_addr_t     wr_addr_i,
  input  wire hdcr_pkg::hdcr_byte_t     wr_data_i,
  input  wire hdcr_pkg::hdcr_addr_t     rd_addr_i,
  output logic [7:0]                    rd_data_o,
  input  wire logic                     rom_up_line_swap_i,
  input  wire logic                     rom_down1_line_swap_i,
  input  wire logic [127:0]             uuid_i,
  input  wire logic                     string_write_gate_i,
  input  wire logic                     serial_write_gate_i,
  output logic                          up_line_swap_o,
  output logic                          down1_line_swap_o,
  output logic [15:0]                   language_code_o,
  output logic [`HDCR_SER_LEN_W-1:0]    serial_string_length_o,
  output logic                          serial_string_enable_o
);
  import hdcr_pkg::*;

  // ----------------------------------------------------------------
  // Reset release.
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // Synchronisers for the ROM bits, the UUID and the gate straps.
  // ----------------------------------------------------------------
  logic [3:0]   in_meta_q;
  logic [3:0]   in_sync_q;
  logic [127:0] uuid_meta_q;
  logic [127:0] uuid_sync_q;
  logic         rom_up;
  logic         rom_down1;
  logic         str_gate;
  logic         ser_gate;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q   <= 4'h0;
      in_sync_q   <= 4'h0;
      uuid_meta_q <= 128'h0;
      uuid_sync_q <= 128'h0;
    end else begin
      in_meta_q   <= {serial_write_gate_i, string_write_gate_i, rom_down1_line_swap_i, rom_up_line_swap_i};
      in_sync_q   <= in_meta_q;
      uuid_meta_q <= uuid_i;
      uuid_sync_q <= uuid_meta_q;
    end
  end
  assign rom_up    = in_sync_q[0];
  assign rom_down1 = in_sync_q[1];
  assign str_gate  = in_sync_q[2];
  assign ser_gate  = in_sync_q[3];

  // ----------------------------------------------------------------
  // Write decode.
  // ----------------------------------------------------------------
  // True when a write strobe targets the given offset.
  function automatic logic wr_hit(input logic       en,
                                  input hdcr_addr_t addr,
                                  input hdcr_addr_t ofs);
    return en && (addr == ofs);
  endfunction

  logic pol_wr;
  logic lang_low_wr;
  logic lang_high_wr;
  logic ser_len_wr;
  assign pol_wr       = wr_hit(wr_en_i, wr_addr_i, `HDCR_OFS_POLARITY);
  assign lang_low_wr  = wr_hit(wr_en_i, wr_addr_i, `HDCR_OFS_LANG_LOW);
  assign lang_high_wr = wr_hit(wr_en_i, wr_addr_i, `HDCR_OFS_LANG_HIGH);
  assign ser_len_wr   = wr_hit(wr_en_i, wr_addr_i, `HDCR_OFS_SER_LEN);

  // ----------------------------------------------------------------
  // Port polarity register.
  // ----------------------------------------------------------------
  logic pol_gate_q;
  logic pol_gate_d;
  logic up_swap_q;
  logic up_swap_d;
  logic dn1_swap_q;
  logic dn1_swap_d;

  always_comb begin
    pol_gate_d = pol_gate_q;
    up_swap_d  = up_swap_q;
    dn1_swap_d = dn1_swap_q;
    if (pol_wr) begin
      pol_gate_d = wr_data_i[`HDCR_BIT_POL_GATE];
    end
    // The gate value of this very write decides whether its swap bits land.
    if (pol_gate_d) begin
      if (pol_wr) begin
        up_swap_d  = wr_data_i[`HDCR_BIT_UP_SWAP];
        dn1_swap_d = wr_data_i[`HDCR_BIT_DOWN1_SWAP];
      end
    end else begin
      // A closed gate makes the swap bits track the ROM on every clock.
      up_swap_d  = rom_up;
      dn1_swap_d = rom_down1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pol_gate_q <= 1'b0;
      up_swap_q  <= 1'b0;
      dn1_swap_q <= 1'b0;
    end else begin
      pol_gate_q <= pol_gate_d;
      up_swap_q  <= up_swap_d;
      dn1_swap_q <= dn1_swap_d;
    end
  end

  // ----------------------------------------------------------------
  // Language code registers.
  // ----------------------------------------------------------------
  hdcr_byte_t lang_low_q;
  hdcr_byte_t lang_low_d;
  hdcr_byte_t lang_high_q;
  hdcr_byte_t lang_high_d;

  always_comb begin
    lang_low_d  = lang_low_q;
    lang_high_d = lang_high_q;
    if (lang_low_wr && str_gate) begin
      lang_low_d = wr_data_i;
    end
    if (lang_high_wr && str_gate) begin
      lang_high_d = wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lang_low_q  <= `HDCR_RST_LANG_LOW;
      lang_high_q <= `HDCR_RST_LANG_HIGH;
    end else begin
      lang_low_q  <= lang_low_d;
      lang_high_q <= lang_high_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial string length register.
  // ----------------------------------------------------------------
  logic [`HDCR_SER_LEN_W-1:0] ser_len_q;
  logic [`HDCR_SER_LEN_W-1:0] ser_len_d;

  always_comb begin
    ser_len_d = ser_len_q;
    if (ser_len_wr && ser_gate) begin
      ser_len_d = wr_data_i[`HDCR_SER_LEN_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_len_q <= `HDCR_RST_SER_LEN;
    end else begin
      ser_len_q <= ser_len_d;
    end
  end

  // ----------------------------------------------------------------
  // Read mux.
  // ----------------------------------------------------------------
  hdcr_byte_t rd_data_d;

  always_comb begin
    rd_data_d = 8'h00;
    if (rd_addr_i >= `HDCR_OFS_UUID_FIRST && rd_addr_i <= `HDCR_OFS_UUID_LAST) begin
      rd_data_d = uuid_sync_q[{rd_addr_i[3:0], 3'h0} +: 8];
    end else begin
      case (rd_addr_i)
        `HDCR_OFS_POLARITY:  rd_data_d = {pol_gate_q, 5'h00, dn1_swap_q, up_swap_q};
        `HDCR_OFS_LANG_LOW:  rd_data_d = lang_low_q;
        `HDCR_OFS_LANG_HIGH: rd_data_d = lang_high_q;
        `HDCR_OFS_SER_LEN:   rd_data_d = {2'h0, ser_len_q};
        default:             rd_data_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor-side outputs.
  // ----------------------------------------------------------------
  assign up_line_swap_o         = up_swap_q;
  assign down1_line_swap_o      = dn1_swap_q;
  assign language_code_o        = {lang_high_q, lang_low_q};
  assign serial_string_length_o = ser_len_q;
  assign serial_string_enable_o = (ser_len_q != 6'h00);
endmodule

// File: dv/hdcr_otp_model.sv
// One-time-programmable source of the port swap bits and the container UUID.
`timescale 1ns/100ps
module hdcr_otp_model (
  output logic         rom_up_o,
  output logic         rom_down1_o,
  output logic [127:0] uuid_o
);
  assign rom_up_o    = 1'b1;
  assign rom_down1_o = 1'b0;
  // Byte 6 carries version 4 and byte 8 the variant 10b of a random UUID.
  assign uuid_o      = 128'h00112233_445566b7_8849aabb_ccddeeff;
endmodule

// File: dv/hdcr_regs_monitor.sv
// Port checker of the hub configuration register bank.
`timescale 1ns/100ps
module hdcr_regs_monitor (
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 wr_en_i,
  input wire hdcr_pkg::hdcr_addr_t wr_addr_i,
  input wire hdcr_pkg::hdcr_byte_t wr_data_i,
  input wire hdcr_pkg::hdcr_addr_t rd_addr_i,
  input wire logic [7:0]           rd_data_o,
  input wire logic [127:0]         uuid_i,
  input wire logic                 string_write_gate_i,
  input wire logic                 serial_write_gate_i,
  input wire logic                 up_line_swap_o,
  input wire logic                 down1_line_swap_o,
  input wire logic [15:0]          language_code_o,
  input wire logic [5:0]           serial_string_length_o,
  input wire logic                 serial_string_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // The design sees each gate strap two clocks late, behind its synchroniser.
  property p_lwr; wr_en_i && wr_addr_i == 8'h20 && $past(string_write_gate_i, 2)
    |=> language_code_o[7:0] == $past(wr_data_i); endproperty
  a_lwr: assert property (p_lwr) else $error("language write lost");
  property p_lkeep; wr_en_i && wr_addr_i == 8'h21 && !$past(string_write_gate_i, 2)
    |=> $stable(language_code_o); endproperty
  a_lkeep: assert property (p_lkeep) else $error("language changed");
  property p_swr; wr_en_i && wr_addr_i == 8'h22 && $past(serial_write_gate_i, 2)
    |=> serial_string_length_o == $past(wr_data_i[5:0]); endproperty
  a_swr: assert property (p_swr) else $error("length write lost");
  property p_skeep; wr_en_i && !$past(serial_write_gate_i, 2) |=> $stable(serial_string_length_o); endproperty
  a_skeep: assert property (p_skeep) else $error("length changed");
  property p_en; serial_string_enable_o == (serial_string_length_o != 6'h00); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_pol; wr_en_i && wr_addr_i == 8'h0b && wr_data_i[7]
    |=> {down1_line_swap_o, up_line_swap_o} == $past(wr_data_i[1:0]); endproperty
  a_pol: assert property (p_pol) else $error("swap write lost");
  property p_rsv; $past(rd_addr_i) == 8'h22 |-> rd_data_o[7:6] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_uid; $past(rd_addr_i[7:4]) == 4'h1 |-> rd_data_o == $past(uuid_i[8*rd_addr_i[3:0]+:8]); endproperty
  a_uid: assert property (p_uid) else $error("uuid byte wrong");
endmodule
bind hdcr_regs hdcr_regs_monitor u_mon (
  .clk_i                  (clk_i),
  .rst_n_i                (rst_n_i),
  .wr_en_i                (wr_en_i),
  .wr_addr_i              (wr_addr_i),
  .wr_data_i              (wr_data_i),
  .rd_addr_i              (rd_addr_i),
  .rd_data_o              (rd_data_o),
  .uuid_i                 (uuid_i),
  .string_write_gate_i    (string_write_gate_i),
  .serial_write_gate_i    (serial_write_gate_i),
  .up_line_swap_o         (up_line_swap_o),
  .down1_line_swap_o      (down1_line_swap_o),
  .language_code_o        (language_code_o),
  .serial_string_length_o (serial_string_length_o),
  .serial_string_enable_o (serial_string_enable_o)
);

// File: dv/hdcr_regs_test.sv
// Self-checking bench of the hub configuration register bank.
`timescale 1ns/100ps
module hdcr_regs_test;
  logic         clk_i = 0, rst_n_i = 0, wr_en_i = 0, sg = 0, ng = 0, rv = 0, rv_q = 0, ru, r1, se, us, ds;
  logic [7:0]   wa = 0, wd = 0, ra = 0, rd, r = 8'h4e;
  logic [15:0]  lc;
  logic [5:0]   sl;
  logic [127:0] uu;
  logic [7:0]   exp_q[$];
  int           fail_count = 0, checks_done = 0;
  hdcr_otp_model otp (.rom_up_o(ru), .rom_down1_o(r1), .uuid_o(uu));
  hdcr_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en_i), .wr_addr_i(wa), .wr_data_i(wd),
    .rd_addr_i(ra), .rd_data_o(rd), .rom_up_line_swap_i(ru), .rom_down1_line_swap_i(r1), .uuid_i(uu),
    .string_write_gate_i(sg), .serial_write_gate_i(ng), .up_line_swap_o(us), .down1_line_swap_o(ds),
    .language_code_o(lc), .serial_string_length_o(sl), .serial_string_enable_o(se));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk_rd(logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_pin(logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    {wr_en_i, wa, wd} = {1'b1, a, d};
    @(posedge clk_i) #2;
    wr_en_i = 0;
    @(posedge clk_i) #2;
  endtask
  task automatic rdx(logic [7:0] a, logic [7:0] e);
    ra = a;
    rv = 1;
    exp_q.push_back(e);
    @(posedge clk_i) #2;
    rv = 0;
    @(posedge clk_i) #2;
  endtask
  always @(posedge clk_i) begin
    if (rv_q) chk_rd(exp_q.pop_front(), rd);
    rv_q <= rv;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    summarize;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    #2 rst_n_i = 1;
    repeat (4) @(posedge clk_i);
    #2 rdx(8'h20, 8'h09);
    rdx(8'h21, 8'h04);
    rdx(8'h22, 8'h18);
    rdx(8'h0b, 8'h01);
    chk_pin(16'h0409, lc);
    chk_pin(16'h0018, {10'h000, sl});
    rdx(8'h05, 8'h00);
    for (int i = 0; i < 16; i++) rdx(8'h10 + 8'(i), uu[8*i+:8]);
    $display("reset and uuid done");
    r = lfsr(r);
    wr(8'h20, r);
    wr(8'h21, r);
    wr(8'h22, r);
    wr(8'h1f, r);
    rdx(8'h20, 8'h09);
    rdx(8'h21, 8'h04);
    rdx(8'h22, 8'h18);
    rdx(8'h1f, uu[127:120]);
    sg = 1;
    ng = 1;
    repeat (4) @(posedge clk_i);
    #2 r = lfsr(r);
    wr(8'h20, ~r);
    rdx(8'h20, ~r);
    wr(8'h21, r);
    rdx(8'h21, r);
    chk_pin({r, ~r}, lc);
    for (int i = 0; i < 2; i++) begin
      wr(8'h22, 8'he0 - 8'(i * 32));
      rdx(8'h22, 8'h20 - 8'(i * 32));
      chk_pin(16'(1 - i), {15'h0000, se});
      chk_pin(16'(32 - i * 32), {10'h000, sl});
    end
    $display("gated writes done");
    wr(8'h0b, 8'h83);
    rdx(8'h0b, 8'h83);
    chk_pin(16'h0003, {14'h0000, ds, us});
    wr(8'h0b, 8'h82);
    rdx(8'h0b, 8'h82);
    chk_pin(16'h0002, {14'h0000, ds, us});
    wr(8'h0b, 8'h02);
    rdx(8'h0b, 8'h01);
    chk_pin(16'h0001, {14'h0000, ds, us});
    $display("polarity done");
    rst_n_i = 0;
    repeat (3) @(posedge clk_i);
    #2 rst_n_i = 1;
    repeat (4) @(posedge clk_i);
    #2 rdx(8'h20, 8'h09);
    rdx(8'h22, 8'h18);
    rdx(8'h0b, 8'h01);
    chk_pin(16'h0409, lc);
    $display("second reset done");
    summarize;
  end
endmodule
